// file: mcr_config_status.sv
// Configuration and status registers of the buffer-memory controller.
// Assumes a synchronous internal register port with one-cycle strobes;
// bit 0 of every byte is the leftmost bit, as on the register bus.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_regs.svh"

module mcr_config_status
    import mcr_pkg::*;
#(
    parameter int ADDR_W = `MCR_ADDR_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic soft_reset_in,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [0:7] reg_wdata_in,
    output logic [0:7] reg_rdata_out,
    // Controller events, bit order as in the FIFO status register
    input wire logic [0:7] fifo_event_in,
    input wire logic incoherence_event_in,
    // Summary read strobe from the common status register
    input wire logic summary_read_in,
    // Clock and burst controls
    output logic burst_length_select_out,
    output logic [2:0] burst_words_out,
    output mcr_ick_e input_clock_select_out,
    output mcr_ock_e output_clock_select_out,
    output logic [2:0] synth_numerator_out,
    output logic [2:0] synth_denominator_out,
    // Status and summaries
    output logic [0:7] fifo_flags_out,
    output logic incoherence_flag_out,
    output logic ctl_fifo_irq_summary_out,
    output logic ctl_nonfifo_irq_summary_out
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    mcr_byte_t fifo_enable_q;
    logic incoherence_flag_enable_q;
    logic burst_length_select_q;
    mcr_ick_e input_clock_select_q;
    mcr_ock_e output_clock_select_q;
    logic [2:0] synth_num_q;
    logic [2:0] synth_den_q;
    logic [2:0] burst_words_q;
    mcr_byte_t fifo_flags_q;
    logic incoherence_flag_q;
    logic fifo_cond_prev_q;
    logic nonfifo_cond_prev_q;
    logic fifo_summary_q;
    logic nonfifo_summary_q;
    mcr_byte_t rdata_q;
    mcr_byte_t rdata_d;

    logic wr_fifo_en;
    logic wr_err_en;
    logic wr_clk_burst;
    logic wr_synth;
    logic rd_fifo_sts;
    logic rd_coh_sts;
    logic fifo_cond;
    logic nonfifo_cond;

    assign wr_fifo_en = reg_wr_in && (reg_addr_in == `MCR_ADDR_FIFO_EN);
    assign wr_err_en = reg_wr_in && (reg_addr_in == `MCR_ADDR_ERR_EN);
    assign wr_clk_burst = reg_wr_in && (reg_addr_in == `MCR_ADDR_CLK_BURST);
    assign wr_synth = reg_wr_in && (reg_addr_in == `MCR_ADDR_SYNTH);
    assign rd_fifo_sts = reg_rd_in && (reg_addr_in == `MCR_ADDR_FIFO_STS);
    assign rd_coh_sts = reg_rd_in && (reg_addr_in == `MCR_ADDR_COH_STS);

    // ****************************************************************
    // Enable registers
    // ****************************************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fifo_enable_q <= `MCR_RST_FIFO_EN;
        end else if (soft_reset_in) begin
            fifo_enable_q <= `MCR_RST_FIFO_EN;
        end else if (wr_fifo_en) begin
            fifo_enable_q <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            incoherence_flag_enable_q <= 1'b0;
        end else if (soft_reset_in) begin
            incoherence_flag_enable_q <= 1'b0;
        end else if (wr_err_en) begin
            incoherence_flag_enable_q <= reg_wdata_in[`MCR_INCOH_EN_BIT];
        end
    end

    // ****************************************************************
    // Clock, burst and synthesiser configuration
    // ****************************************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            burst_length_select_q <= 1'b0;
            input_clock_select_q <= MCR_ICK_MEMORY;
            output_clock_select_q <= MCR_OCK_HALF_INPUT;
        end else if (soft_reset_in) begin
            burst_length_select_q <= 1'b0;
            input_clock_select_q <= MCR_ICK_MEMORY;
            output_clock_select_q <= MCR_OCK_HALF_INPUT;
        end else if (wr_clk_burst) begin
            burst_length_select_q <= reg_wdata_in[`MCR_BURST_BIT];
            input_clock_select_q <=
                mcr_ick_e'(reg_wdata_in[`MCR_ICK_LO:`MCR_ICK_HI]);
            output_clock_select_q <= mcr_ock_e'(reg_wdata_in[`MCR_OCK_BIT]);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            synth_num_q <= 3'h0;
            synth_den_q <= 3'h0;
        end else if (soft_reset_in) begin
            synth_num_q <= 3'h0;
            synth_den_q <= 3'h0;
        end else if (wr_synth) begin
            synth_num_q <= reg_wdata_in[`MCR_SYN_N_LO:`MCR_SYN_N_HI];
            synth_den_q <= reg_wdata_in[`MCR_SYN_M_LO:`MCR_SYN_M_HI];
        end
    end

    // Words per memory burst
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            burst_words_q <= `MCR_BURST_SHORT;
        end else begin
            burst_words_q <= burst_length_select_q ? `MCR_BURST_LONG
                                                   : `MCR_BURST_SHORT;
        end
    end

    // ****************************************************************
    // Status flags: set wins over clear on read
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_fifo_flag
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    fifo_flags_q[gi] <= 1'b0;
                end else if (soft_reset_in) begin
                    fifo_flags_q[gi] <= 1'b0;
                end else if (fifo_event_in[gi] && fifo_enable_q[gi]) begin
                    fifo_flags_q[gi] <= 1'b1;
                end else if (rd_fifo_sts) begin
                    fifo_flags_q[gi] <= 1'b0;
                end
            end

            a_fifo_flag_set: assert property (
                @(posedge clk_in) disable iff (!arst_n_in || soft_reset_in)
                (fifo_event_in[gi] && fifo_enable_q[gi]) |=> fifo_flags_q[gi])
                else $error("FIFO flag not set by enabled event");

            a_fifo_flag_gate: assert property (
                @(posedge clk_in) disable iff (!arst_n_in || soft_reset_in)
                $rose(fifo_flags_q[gi]) |-> $past(fifo_enable_q[gi]))
                else $error("FIFO flag set while its enable was clear");
        end
    endgenerate

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            incoherence_flag_q <= 1'b0;
        end else if (soft_reset_in) begin
            incoherence_flag_q <= 1'b0;
        end else if (incoherence_event_in && incoherence_flag_enable_q) begin
            incoherence_flag_q <= 1'b1;
        end else if (rd_coh_sts) begin
            incoherence_flag_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Summaries: set on rising enabled condition, clear on read
    // ****************************************************************
    assign fifo_cond = |(fifo_event_in & fifo_enable_q);
    assign nonfifo_cond = incoherence_event_in && incoherence_flag_enable_q;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fifo_cond_prev_q <= 1'b0;
            nonfifo_cond_prev_q <= 1'b0;
        end else if (soft_reset_in) begin
            fifo_cond_prev_q <= 1'b0;
            nonfifo_cond_prev_q <= 1'b0;
        end else begin
            fifo_cond_prev_q <= fifo_cond;
            nonfifo_cond_prev_q <= nonfifo_cond;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            fifo_summary_q <= 1'b0;
        end else if (soft_reset_in) begin
            fifo_summary_q <= 1'b0;
        end else if (fifo_cond && !fifo_cond_prev_q) begin
            fifo_summary_q <= 1'b1;
        end else if (summary_read_in) begin
            fifo_summary_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            nonfifo_summary_q <= 1'b0;
        end else if (soft_reset_in) begin
            nonfifo_summary_q <= 1'b0;
        end else if (nonfifo_cond && !nonfifo_cond_prev_q) begin
            nonfifo_summary_q <= 1'b1;
        end else if (summary_read_in) begin
            nonfifo_summary_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr_in)
            `MCR_ADDR_FIFO_EN: begin
                rdata_d = fifo_enable_q;
            end
            `MCR_ADDR_ERR_EN: begin
                rdata_d[`MCR_INCOH_EN_BIT] = incoherence_flag_enable_q;
            end
            `MCR_ADDR_CLK_BURST: begin
                rdata_d[`MCR_BURST_BIT] = burst_length_select_q;
                rdata_d[`MCR_ICK_LO:`MCR_ICK_HI] = input_clock_select_q;
                rdata_d[`MCR_OCK_BIT] = output_clock_select_q;
            end
            `MCR_ADDR_SYNTH: begin
                rdata_d[`MCR_SYN_N_LO:`MCR_SYN_N_HI] = synth_num_q;
                rdata_d[`MCR_SYN_M_LO:`MCR_SYN_M_HI] = synth_den_q;
            end
            `MCR_ADDR_FIFO_STS: begin
                rdata_d = fifo_flags_q;
            end
            `MCR_ADDR_COH_STS: begin
                rdata_d[`MCR_INCOH_STS_BIT] = incoherence_flag_q;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_q <= 8'h00;
        end else if (reg_rd_in) begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata_out = rdata_q;
    assign burst_length_select_out = burst_length_select_q;
    assign burst_words_out = burst_words_q;
    assign input_clock_select_out = input_clock_select_q;
    assign output_clock_select_out = output_clock_select_q;
    assign synth_numerator_out = synth_num_q;
    assign synth_denominator_out = synth_den_q;
    assign fifo_flags_out = fifo_flags_q;
    assign incoherence_flag_out = incoherence_flag_q;
    assign ctl_fifo_irq_summary_out = fifo_summary_q;
    assign ctl_nonfifo_irq_summary_out = nonfifo_summary_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in || soft_reset_in);

    sequence s_clk_write;
        wr_clk_burst ##1 1'b1;
    endsequence
    sequence s_summary_cleared;
        summary_read_in ##0 !(fifo_cond && !fifo_cond_prev_q);
    endsequence

    a_incoh_gate: assert property (
        !incoherence_flag_enable_q && !incoherence_flag_q |=>
            !incoherence_flag_q && !$rose(nonfifo_summary_q))
        else $error("Incoherence flag or summary rose while disabled");
    a_incoh_set: assert property (
        incoherence_event_in && incoherence_flag_enable_q |=> incoherence_flag_q)
        else $error("Incoherence flag missed an enabled event");
    a_burst_words: assert property (
        s_clk_write ##1 1'b1 |->
            burst_words_out == ($past(burst_length_select_out) ? 3'h4 : 3'h2))
        else $error("Burst word count does not follow burst bit");
    a_ick_follow: assert property (
        wr_clk_burst |=>
            input_clock_select_out == $past(reg_wdata_in[2:3]))
        else $error("Input clock select did not take written field");
    a_ock_follow: assert property (
        wr_clk_burst |=> output_clock_select_out == $past(reg_wdata_in[7]))
        else $error("Output clock select did not take written bit");
    a_synth_follow: assert property (
        wr_synth |=> synth_numerator_out == $past(reg_wdata_in[1:3]) &&
            synth_denominator_out == $past(reg_wdata_in[5:7]))
        else $error("Synthesiser factors did not take written fields");
    a_fifo_sum_set: assert property (
        fifo_cond && !fifo_cond_prev_q |=> fifo_summary_q [*1]
            ##0 !$past(fifo_cond_prev_q))
        else $error("FIFO summary missed a new enabled flag");
    a_fifo_sum_clear: assert property (
        s_summary_cleared |=> !fifo_summary_q)
        else $error("FIFO summary not cleared by read");
    a_fifo_sum_rearm: assert property (
        !fifo_summary_q && fifo_cond_prev_q && fifo_cond |=> !fifo_summary_q)
        else $error("FIFO summary reasserted without a new edge");
    a_nonfifo_sum: assert property (
        nonfifo_cond && !nonfifo_cond_prev_q |=> nonfifo_summary_q)
        else $error("Non-FIFO summary missed a new enabled event");
    a_rsvd_zero: assert property (
        reg_rd_in && (reg_addr_in == `MCR_ADDR_RSVD_A ||
            reg_addr_in == `MCR_ADDR_RSVD_B || reg_addr_in == `MCR_ADDR_RSVD_C)
            |=> reg_rdata_out == 8'h00)
        else $error("Reserved address read nonzero");
endmodule : mcr_config_status
`default_nettype wire

// file: mcr_config_status_bench.sv
// Self-checking bench for the memory controller configuration and status slice.
// Assumes mcr_pkg.sv and mcr_regs.svh are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_regs.svh"

module mcr_config_status_bench;

    // ****************************************
    // Signals and design
    // ****************************************
    logic clk_in = 1'h0;
    logic arst_n_in = 1'h0;
    logic soft_reset_in = 1'h0;
    logic [19:0] reg_addr_in = 20'h00000;
    logic reg_wr_in = 1'h0;
    logic reg_rd_in = 1'h0;
    logic [0:7] reg_wdata_in = 8'h00;
    logic [0:7] fifo_event_in = 8'h00;
    logic incoherence_event_in = 1'h0;
    logic summary_read_in = 1'h0;
    logic [0:7] reg_rdata_out;
    logic [0:7] fifo_flags_out;
    logic burst_length_select_out;
    logic [2:0] burst_words_out;
    mcr_pkg::mcr_ick_e input_clock_select_out;
    mcr_pkg::mcr_ock_e output_clock_select_out;
    logic [2:0] synth_numerator_out;
    logic [2:0] synth_denominator_out;
    logic incoherence_flag_out;
    logic ctl_fifo_irq_summary_out;
    logic ctl_nonfifo_irq_summary_out;
    int miscompares = 0;
    int tests_run = 0;
    logic [19:0] all_addr [10] = '{20'h30B01, 20'h30B02, 20'h30B03, 20'h30B04, 20'h30B05,
        20'h30B06, 20'h30B07, 20'h30B08, 20'h30B09, 20'h30B0A};
    logic [19:0] ro_addr [6] = '{20'h30B05, 20'h30B06, 20'h30B07, 20'h30B08, 20'h30B09,
        20'h30B0A};

    mcr_config_status i_mcr_config_status (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .soft_reset_in(soft_reset_in),
        .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out),
        .fifo_event_in(fifo_event_in),
        .incoherence_event_in(incoherence_event_in),
        .summary_read_in(summary_read_in),
        .burst_length_select_out(burst_length_select_out),
        .burst_words_out(burst_words_out),
        .input_clock_select_out(input_clock_select_out),
        .output_clock_select_out(output_clock_select_out),
        .synth_numerator_out(synth_numerator_out),
        .synth_denominator_out(synth_denominator_out),
        .fifo_flags_out(fifo_flags_out),
        .incoherence_flag_out(incoherence_flag_out),
        .ctl_fifo_irq_summary_out(ctl_fifo_irq_summary_out),
        .ctl_nonfifo_irq_summary_out(ctl_nonfifo_irq_summary_out)
    );

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick;
        @(posedge clk_in);
        #2;
    endtask : tick

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reg_write(input logic [19:0] addr, input logic [7:0] data);
        tick();
        reg_addr_in = addr;
        reg_wdata_in = data;
        reg_wr_in = 1'h1;
        tick();
        reg_wr_in = 1'h0;
    endtask : reg_write

    task automatic reg_read(input logic [19:0] addr, input logic [7:0] exp, input string what);
        tick();
        reg_addr_in = addr;
        reg_rd_in = 1'h1;
        tick();
        reg_rd_in = 1'h0;
        chk(what, exp, reg_rdata_out);
    endtask : reg_read

    task automatic summary_clear;
        tick();
        summary_read_in = 1'h1;
        tick();
        summary_read_in = 1'h0;
    endtask : summary_clear

    task automatic tally_and_finish;
        $display("Counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        tally_and_finish();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [7:0] d;
        repeat (10) @(posedge clk_in);
        #2;
        arst_n_in = 1'h1;
        chk("burst_words_reset", 8'h02, 8'(burst_words_out));
        foreach (all_addr[k]) reg_read(all_addr[k], 8'h00, "reset_value");
        foreach (ro_addr[k]) reg_write(ro_addr[k], 8'hFF);
        foreach (ro_addr[k]) reg_read(ro_addr[k], 8'h00, "read_only_reg");
        reg_write(`MCR_ADDR_CLK_BURST, 8'hFF);
        reg_read(`MCR_ADDR_CLK_BURST, 8'hB1, "clk_burst_mask");
        for (int i = 0; i < 4; i++) begin
            d = {i[0], 1'h0, i[1:0], 3'h0, i[1]};
            reg_write(`MCR_ADDR_CLK_BURST, d);
            chk("burst_select", 8'(i[0]), 8'(burst_length_select_out));
            chk("input_clock", 8'(i[1:0]), 8'(input_clock_select_out));
            chk("output_clock", 8'(i[1]), 8'(output_clock_select_out));
            tick();
            chk("burst_words", i[0] ? 8'h04 : 8'h02, 8'(burst_words_out));
            reg_read(`MCR_ADDR_CLK_BURST, d, "clk_burst_reg");
        end
        reg_write(`MCR_ADDR_SYNTH, 8'hFF);
        reg_read(`MCR_ADDR_SYNTH, 8'h77, "synth_mask");
        reg_write(`MCR_ADDR_SYNTH, 8'h35);
        chk("synth_numerator", 8'h03, 8'(synth_numerator_out));
        chk("synth_denominator", 8'h05, 8'(synth_denominator_out));
        reg_read(`MCR_ADDR_SYNTH, 8'h35, "synth_reg");
        // One enable at a time, all events firing
        for (int i = 0; i < 8; i++) begin
            d = 8'h80 >> i;
            reg_write(`MCR_ADDR_FIFO_EN, d);
            reg_read(`MCR_ADDR_FIFO_EN, d, "fifo_enable_reg");
            tick();
            fifo_event_in = 8'hFF;
            tick();
            fifo_event_in = 8'h00;
            chk("fifo_flags", d, fifo_flags_out);
            chk("fifo_summary", 8'h01, 8'(ctl_fifo_irq_summary_out));
            reg_read(`MCR_ADDR_FIFO_STS, d, "fifo_status_reg");
            reg_read(`MCR_ADDR_FIFO_STS, 8'h00, "fifo_status_cleared");
            summary_clear();
            chk("fifo_summary_clear", 8'h00, 8'(ctl_fifo_irq_summary_out));
        end
        // Persisting condition must not re-arm the summary
        reg_write(`MCR_ADDR_FIFO_EN, 8'h80);
        tick();
        fifo_event_in = 8'h80;
        tick();
        chk("fifo_summary_set", 8'h01, 8'(ctl_fifo_irq_summary_out));
        summary_clear();
        repeat (3) tick();
        chk("fifo_summary_held", 8'h00, 8'(ctl_fifo_irq_summary_out));
        reg_read(`MCR_ADDR_FIFO_STS, 8'h80, "fifo_status_persist");
        reg_read(`MCR_ADDR_FIFO_STS, 8'h80, "fifo_status_set_wins");
        fifo_event_in = 8'h00;
        repeat (2) tick();
        fifo_event_in = 8'h80;
        tick();
        fifo_event_in = 8'h00;
        chk("fifo_summary_rearm", 8'h01, 8'(ctl_fifo_irq_summary_out));
        summary_clear();
        // Incoherence flag, disabled then enabled
        for (int e = 0; e < 2; e++) begin
            reg_write(`MCR_ADDR_ERR_EN, e[0] ? 8'hFF : 8'h00);
            reg_read(`MCR_ADDR_ERR_EN, 8'(e[0]), "error_enable_reg");
            tick();
            incoherence_event_in = 1'h1;
            tick();
            incoherence_event_in = 1'h0;
            chk("incoherence_flag", 8'(e[0]), 8'(incoherence_flag_out));
            chk("nonfifo_summary", 8'(e[0]), 8'(ctl_nonfifo_irq_summary_out));
            reg_read(`MCR_ADDR_COH_STS, 8'(e[0]), "coherence_status_reg");
        end
        reg_read(`MCR_ADDR_COH_STS, 8'h00, "coherence_status_cleared");
        summary_clear();
        chk("nonfifo_summary_clear", 8'h00, 8'(ctl_nonfifo_irq_summary_out));
        // Controller soft reset restores configuration
        reg_write(`MCR_ADDR_CLK_BURST, 8'h91);
        tick();
        soft_reset_in = 1'h1;
        tick();
        soft_reset_in = 1'h0;
        tick();
        chk("burst_words_soft", 8'h02, 8'(burst_words_out));
        reg_read(`MCR_ADDR_CLK_BURST, 8'h00, "clk_burst_soft");
        reg_read(`MCR_ADDR_FIFO_EN, 8'h00, "fifo_enable_soft");
        tally_and_finish();
    end

endmodule : mcr_config_status_bench
`default_nettype wire

// file: mcr_pkg.sv
// Types shared by the memory controller register slice.
// Assumes mcr_regs.svh is compiled alongside.
`default_nettype none
package mcr_pkg;

    typedef logic [0:7] mcr_byte_t;

    typedef enum logic [1:0] {
        MCR_ICK_MEMORY = 2'b00,
        MCR_ICK_LINK_ONE = 2'b01,
        MCR_ICK_LINK_TWO = 2'b10,
        MCR_ICK_FABRIC = 2'b11
    } mcr_ick_e;

    typedef enum logic {
        MCR_OCK_HALF_INPUT = 1'b0,
        MCR_OCK_SYNTH = 1'b1
    } mcr_ock_e;

endpackage : mcr_pkg
`default_nettype wire

// file: mcr_regs.svh
// Register offsets, field positions and reset values of the memory
// controller configuration and status slice.
// Assumes 20-bit absolute byte addresses on the internal register port.
`ifndef MCR_REGS_SVH
`define MCR_REGS_SVH

`define MCR_ADDR_W 20
`define MCR_ADDR_FIFO_EN 20'h30B01
`define MCR_ADDR_ERR_EN 20'h30B02
`define MCR_ADDR_CLK_BURST 20'h30B03
`define MCR_ADDR_SYNTH 20'h30B04
`define MCR_ADDR_RSVD_A 20'h30B05
`define MCR_ADDR_RSVD_B 20'h30B06
`define MCR_ADDR_FIFO_STS 20'h30B08
`define MCR_ADDR_COH_STS 20'h30B09
`define MCR_ADDR_RSVD_C 20'h30B0A

`define MCR_INCOH_EN_BIT 7
`define MCR_BURST_BIT 0
`define MCR_ICK_LO 2
`define MCR_ICK_HI 3
`define MCR_OCK_BIT 7
`define MCR_SYN_N_LO 1
`define MCR_SYN_N_HI 3
`define MCR_SYN_M_LO 5
`define MCR_SYN_M_HI 7
`define MCR_INCOH_STS_BIT 7

`define MCR_RST_FIFO_EN 8'h00
`define MCR_RST_ERR_EN 8'h00
`define MCR_RST_CLK_BURST 8'h00
`define MCR_RST_SYNTH 8'h00
`define MCR_RST_STATUS 8'h00

`define MCR_BURST_SHORT 3'h2
`define MCR_BURST_LONG 3'h4

`endif
